// >>> design/sese_bus_cycle.sv
// One flash bus cycle: write or read with chip-enable framing
`timescale 1ns/100ps
`default_nettype none
module sese_bus_cycle
  import sese_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire sese_step_t step,
  input wire logic [DATA_W-1:0] dq_in,
  output logic done_ff,
  output logic [DATA_W-1:0] rdata_ff,
  output logic [ADDR_W-1:0] addr_ff,
  output logic [DATA_W-1:0] dq_out_ff,
  output logic dq_oe_ff,
  output logic ce_n_ff,
  output logic we_n_ff,
  output logic oe_n_ff
);
  typedef enum logic [1:0] {
    BC_IDLE = 2'b00,
    BC_SETUP = 2'b01,
    BC_STROBE = 2'b10,
    BC_HOLD = 2'b11
  } sese_bc_t;

  sese_bc_t bc_ff;
  logic wr_ff;
  logic [7:0] cnt_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bc_ff <= BC_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      addr_ff <= ZERO_ADDR;
      dq_out_ff <= 16'h0000;
      dq_oe_ff <= 1'b0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      case (bc_ff)
        BC_IDLE: begin
          if (start) begin
            bc_ff <= BC_SETUP;
            wr_ff <= step.is_write;
            addr_ff <= step.addr;
            dq_out_ff <= {8'h00, step.data};
            dq_oe_ff <= step.is_write;
            ce_n_ff <= 1'b0;
          end
        end
        BC_SETUP: begin
          bc_ff <= BC_STROBE;
          cnt_ff <= 8'(STROBE_CYC - 1);
          we_n_ff <= ~wr_ff;
          oe_n_ff <= wr_ff;
        end
        BC_STROBE: begin
          if (cnt_ff == 8'h00) begin
            bc_ff <= BC_HOLD;
            we_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            if (!wr_ff) begin
              rdata_ff <= dq_in;
            end
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        BC_HOLD: begin
          bc_ff <= BC_IDLE;
          ce_n_ff <= 1'b1;
          dq_oe_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        default: bc_ff <= BC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> design/sese_host.sv
// Host sequencer driving sector erase, suspend and autoselect cycles
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Sector erase is issued as exactly six write cycles.
// - Two unlocks, setup 80, two unlocks, then sector address with 30.
// - Host adds sectors only while under 80 us since previous write.
// - Hardware reset aborts erase; host must reissue whole sequence.
// - Suspend and resume carry bank address of a queued sector.
// - Secure entry is AA at 555, 55 at 2AA, 88 at 555.
// - Protect verify writes AA, 55, 90 then reads sector plus X02.
module sese_host
  import sese_pkg::*;
#(
  parameter int WINDOW_CYC = WINDOW_CYC_DEF,
  parameter int SUSPEND_CYC = SUSPEND_CYC_DEF
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire sese_cmd_t cmd,
  output logic cmd_ready_ff,
  output logic done_ff,
  output logic refused_ff,
  output logic [DATA_W-1:0] rdata_ff,
  output logic erase_active_ff,
  output logic suspended_ff,
  output logic window_open_ff,
  output logic erase_window_expired_flag_ff,
  output logic [ADDR_W-1:0] flash_addr_ff,
  output logic [DATA_W-1:0] flash_dq_out_ff,
  output logic flash_dq_oe_ff,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n_ff,
  output logic flash_we_n_ff,
  output logic flash_oe_n_ff,
  output logic flash_rst_n_ff,
  input wire logic ready_busy_output
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_SUSP = 3'b011,
    ST_HWRST = 3'b100
  } sese_st_t;

  sese_st_t st_ff;
  sese_cmd_t cur_ff;
  logic [2:0] step_ff;
  logic [2:0] op_writes_ff;
  logic [CNT_W-1:0] win_cnt_ff;
  logic [CNT_W-1:0] wait_cnt_ff;
  logic [BANK_HI-BANK_LO:0] erase_bank_ff;
  logic busy_seen_ff;
  logic bc_start;
  logic bc_done;
  logic [DATA_W-1:0] bc_rdata;
  sese_step_t cur_step;
  logic [2:0] cur_len;
  logic refuse;

  function automatic logic [2:0] seq_len(input sese_op_t op);
    case (op)
      OP_SECTOR_ERASE: seq_len = 3'(ERASE_WRITES);
      OP_SECURE_ENTER: seq_len = 3'd3;
      OP_PROT_VERIFY: seq_len = 3'd4;
      OP_LOCK_READ: seq_len = 3'd4;
      default: seq_len = 3'd1;
    endcase
  endfunction

  function automatic sese_step_t seq_step(input sese_cmd_t c, input logic [2:0] s,
                                          input logic [BANK_HI-BANK_LO:0] eb);
    logic [ADDR_W-1:0] sect;
    logic [BANK_HI-BANK_LO:0] bank;
    sect = {c.addr[SECT_HI:SECT_LO], SECT_ZERO_OFS};
    bank = c.addr[BANK_HI:BANK_LO];
    seq_step = '{1'b1, ZERO_ADDR, D_NONE};
    case (c.op)
      OP_SECTOR_ERASE: begin
        case (s)
          3'd0, 3'd3: seq_step = '{1'b1, UNLOCK_A1, D_UNLOCK1};
          3'd1, 3'd4: seq_step = '{1'b1, UNLOCK_A2, D_UNLOCK2};
          3'd2: seq_step = '{1'b1, UNLOCK_A1, D_ERASE_SETUP};
          default: seq_step = '{1'b1, sect, D_SECTOR_ERASE};
        endcase
      end
      OP_ADD_SECTOR: seq_step = '{1'b1, sect, D_SECTOR_ERASE};
      OP_SUSPEND: seq_step = '{1'b1, {eb, BANK_ZERO_OFS}, D_SUSPEND};
      OP_RESUME: seq_step = '{1'b1, {eb, BANK_ZERO_OFS}, D_RESUME};
      OP_SECURE_ENTER, OP_PROT_VERIFY, OP_LOCK_READ: begin
        case (s)
          3'd0: seq_step = '{1'b1, UNLOCK_A1, D_UNLOCK1};
          3'd1: seq_step = '{1'b1, UNLOCK_A2, D_UNLOCK2};
          3'd2: begin
            if (c.op == OP_SECURE_ENTER) begin
              seq_step = '{1'b1, UNLOCK_A1, D_SECURE_ENTER};
            end else begin
              seq_step = '{1'b1, {bank, BANK_CMD_OFS}, D_AUTOSELECT};
            end
          end
          default: begin
            if (c.op == OP_PROT_VERIFY) begin
              seq_step = '{1'b0, {c.addr[SECT_HI:SECT_LO], PROT_OFS}, D_NONE};
            end else begin
              seq_step = '{1'b0, {bank, LOCK_IND_OFS}, D_NONE};
            end
          end
        endcase
      end
      OP_RESET: seq_step = '{1'b1, ZERO_ADDR, D_RESET};
      OP_READ: seq_step = '{1'b0, c.addr, D_NONE};
      default: seq_step = '{1'b1, ZERO_ADDR, D_NONE};
    endcase
  endfunction

  always_comb begin
    cur_step = seq_step(cur_ff, step_ff, erase_bank_ff);
    cur_len = seq_len(cur_ff.op);
    bc_start = (st_ff == ST_RUN);
    refuse = 1'b0;
    case (cmd.op)
      OP_ADD_SECTOR: refuse = !window_open_ff || suspended_ff;
      OP_SUSPEND: refuse = !erase_active_ff || suspended_ff;
      OP_RESUME: refuse = !suspended_ff;
      OP_HW_RESET: refuse = 1'b0;
      OP_RESET: refuse = erase_active_ff && !suspended_ff && !window_open_ff;
      default: refuse = erase_active_ff && !suspended_ff;
    endcase
  end

  sese_bus_cycle u_bus (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(bc_start),
    .step(cur_step),
    .dq_in(flash_dq_in),
    .done_ff(bc_done),
    .rdata_ff(bc_rdata),
    .addr_ff(flash_addr_ff),
    .dq_out_ff(flash_dq_out_ff),
    .dq_oe_ff(flash_dq_oe_ff),
    .ce_n_ff(flash_ce_n_ff),
    .we_n_ff(flash_we_n_ff),
    .oe_n_ff(flash_oe_n_ff)
  );

  // Command sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      cur_ff <= '0;
      step_ff <= 3'd0;
      op_writes_ff <= 3'd0;
      wait_cnt_ff <= '0;
      cmd_ready_ff <= 1'b1;
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      flash_rst_n_ff <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (cmd_valid) begin
            if (refuse) begin
              refused_ff <= 1'b1;
            end else begin
              cur_ff <= cmd;
              step_ff <= 3'd0;
              op_writes_ff <= 3'd0;
              cmd_ready_ff <= 1'b0;
              if (cmd.op == OP_HW_RESET) begin
                st_ff <= ST_HWRST;
                flash_rst_n_ff <= 1'b0;
                wait_cnt_ff <= CNT_W'(HWRST_CYC);
              end else begin
                st_ff <= ST_RUN;
              end
            end
          end
        end
        ST_RUN: begin
          st_ff <= ST_WAIT;
          if (cur_step.is_write) begin
            op_writes_ff <= op_writes_ff + 3'd1;
          end
        end
        ST_WAIT: begin
          if (bc_done) begin
            if (!cur_step.is_write) begin
              rdata_ff <= bc_rdata;
            end
            if (step_ff != cur_len - 3'd1) begin
              step_ff <= step_ff + 3'd1;
              st_ff <= ST_RUN;
            end else if (cur_ff.op == OP_SUSPEND && !window_open_ff) begin
              st_ff <= ST_SUSP;
              wait_cnt_ff <= CNT_W'(SUSPEND_CYC);
            end else begin
              st_ff <= ST_IDLE;
              cmd_ready_ff <= 1'b1;
              done_ff <= 1'b1;
            end
          end
        end
        ST_SUSP, ST_HWRST: begin
          if (wait_cnt_ff <= CNT_W'(1)) begin
            st_ff <= ST_IDLE;
            cmd_ready_ff <= 1'b1;
            done_ff <= 1'b1;
            flash_rst_n_ff <= 1'b1;
          end else begin
            wait_cnt_ff <= wait_cnt_ff - CNT_W'(1);
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Acceptance window timing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      win_cnt_ff <= '0;
      window_open_ff <= 1'b0;
      erase_window_expired_flag_ff <= 1'b0;
    end else if (st_ff == ST_HWRST || (st_ff == ST_WAIT && bc_done &&
                 cur_ff.op == OP_SUSPEND)) begin
      win_cnt_ff <= '0;
      window_open_ff <= 1'b0;
      erase_window_expired_flag_ff <= 1'b1;
    end else if (st_ff == ST_WAIT && bc_done && step_ff == cur_len - 3'd1 &&
                 (cur_ff.op == OP_SECTOR_ERASE || cur_ff.op == OP_ADD_SECTOR)) begin
      win_cnt_ff <= CNT_W'(WINDOW_CYC);
      window_open_ff <= 1'b1;
      erase_window_expired_flag_ff <= 1'b0;
    end else if (st_ff == ST_WAIT && bc_done && cur_ff.op == OP_RESET &&
                 window_open_ff) begin
      win_cnt_ff <= '0;
      window_open_ff <= 1'b0;
    end else if (win_cnt_ff != '0) begin
      win_cnt_ff <= win_cnt_ff - CNT_W'(1);
      window_open_ff <= (win_cnt_ff != CNT_W'(1));
      erase_window_expired_flag_ff <= (win_cnt_ff == CNT_W'(1));
    end
  end

  // Erase and suspend tracking
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      erase_active_ff <= 1'b0;
      suspended_ff <= 1'b0;
      busy_seen_ff <= 1'b0;
      erase_bank_ff <= '0;
    end else if (st_ff == ST_HWRST) begin
      erase_active_ff <= 1'b0;
      suspended_ff <= 1'b0;
      busy_seen_ff <= 1'b0;
    end else if (st_ff == ST_IDLE && cmd_valid && !refuse &&
                 cmd.op == OP_SECTOR_ERASE) begin
      erase_active_ff <= 1'b1;
      busy_seen_ff <= 1'b0;
      erase_bank_ff <= cmd.addr[BANK_HI:BANK_LO];
    end else if ((st_ff == ST_SUSP && wait_cnt_ff <= CNT_W'(1)) ||
                 (st_ff == ST_WAIT && bc_done && cur_ff.op == OP_SUSPEND &&
                  window_open_ff)) begin
      suspended_ff <= 1'b1;
    end else if (st_ff == ST_WAIT && bc_done && cur_ff.op == OP_RESUME) begin
      suspended_ff <= 1'b0;
      busy_seen_ff <= 1'b0;
    end else if (st_ff == ST_WAIT && bc_done && cur_ff.op == OP_RESET &&
                 window_open_ff) begin
      erase_active_ff <= 1'b0;
      busy_seen_ff <= 1'b0;
    end else if (erase_active_ff && !suspended_ff && !window_open_ff &&
                 st_ff != ST_SUSP) begin
      if (!ready_busy_output) begin
        busy_seen_ff <= 1'b1;
      end else if (busy_seen_ff) begin
        erase_active_ff <= 1'b0;
        busy_seen_ff <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence erase_done_s;
    done_ff && cur_ff.op == OP_SECTOR_ERASE;
  endsequence

  sequence add_refused_s;
    st_ff == ST_IDLE && cmd_valid && cmd.op == OP_ADD_SECTOR && !window_open_ff;
  endsequence

  erase_six_writes_a: assert property (erase_done_s |-> op_writes_ff == 3'd6)
    else $error("sector erase did not issue six writes");
  erase_last_write_a: assert property (bc_start && cur_ff.op == OP_SECTOR_ERASE &&
    step_ff == 3'd5 |-> cur_step.data == D_SECTOR_ERASE &&
    cur_step.addr[SECT_LO-1:0] == SECT_ZERO_OFS)
    else $error("sixth erase cycle wrong");
  window_open_a: assert property ($rose(window_open_ff) |-> window_open_ff[*8])
    else $error("window closed too early");
  add_refused_a: assert property (add_refused_s |=> refused_ff && st_ff == ST_IDLE)
    else $error("late sector add not refused");
  window_start_a: assert property (st_ff == ST_WAIT && bc_done &&
    cur_ff.op == OP_ADD_SECTOR |=> window_open_ff && win_cnt_ff == CNT_W'(WINDOW_CYC))
    else $error("window not restarted");
  secure_refused_a: assert property (st_ff == ST_IDLE && cmd_valid &&
    cmd.op == OP_SECURE_ENTER && erase_active_ff && !suspended_ff |=> refused_ff)
    else $error("secure entry not refused");
  suspend_bank_a: assert property (bc_start && cur_ff.op == OP_SUSPEND |->
    cur_step.addr[BANK_HI:BANK_LO] == erase_bank_ff && cur_step.data == D_SUSPEND)
    else $error("suspend to wrong bank");
  hw_reset_a: assert property (st_ff == ST_IDLE && cmd_valid && cmd.op == OP_HW_RESET
    |=> !flash_rst_n_ff ##1 !erase_active_ff && !suspended_ff)
    else $error("hardware reset did not abort");
  reset_abort_a: assert property (st_ff == ST_WAIT && bc_done && cur_ff.op == OP_RESET &&
    window_open_ff |=> !erase_active_ff && !window_open_ff)
    else $error("reset in window did not abort");
  resume_clear_a: assert property (st_ff == ST_WAIT && bc_done && cur_ff.op == OP_RESUME
    |=> !suspended_ff)
    else $error("resume left bank suspended");
  secure_third_a: assert property (bc_start && cur_ff.op == OP_SECURE_ENTER &&
    step_ff == 3'd2 |-> cur_step.addr == UNLOCK_A1 && cur_step.data == D_SECURE_ENTER)
    else $error("secure entry third cycle wrong");
endmodule
`default_nettype wire

// >>> design/sese_pkg.sv
// Constants and types for the sector erase and suspend host sequencer
package sese_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WINDOW_US = 80;
  localparam int WINDOW_CYC_DEF = (WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int SUSPEND_US = 20;
  localparam int SUSPEND_CYC_DEF = (SUSPEND_US * 1000) / CLK_PERIOD_NS;
  localparam int HWRST_NS = 500;
  localparam int HWRST_CYC = (HWRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int ERASE_WRITES = 6;
  localparam int BANK_HI = 20;
  localparam int BANK_LO = 18;
  localparam int SECT_HI = 20;
  localparam int SECT_LO = 12;
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002AA;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 21'h000000;
  localparam logic [17:0] BANK_CMD_OFS = 18'h00555;
  localparam logic [17:0] BANK_ZERO_OFS = 18'h00000;
  localparam logic [17:0] LOCK_IND_OFS = 18'h00003;
  localparam logic [11:0] PROT_OFS = 12'h002;
  localparam logic [11:0] SECT_ZERO_OFS = 12'h000;
  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_ERASE_SETUP = 8'h80;
  localparam logic [7:0] D_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hB0;
  localparam logic [7:0] D_SECURE_ENTER = 8'h88;
  localparam logic [7:0] D_AUTOSELECT = 8'h90;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_NONE = 8'h00;

  typedef enum logic [3:0] {
    OP_SECTOR_ERASE = 4'h0,
    OP_ADD_SECTOR = 4'h1,
    OP_SUSPEND = 4'h2,
    OP_RESUME = 4'h3,
    OP_SECURE_ENTER = 4'h4,
    OP_PROT_VERIFY = 4'h5,
    OP_LOCK_READ = 4'h6,
    OP_RESET = 4'h7,
    OP_READ = 4'h8,
    OP_HW_RESET = 4'h9
  } sese_op_t;

  typedef struct packed {
    sese_op_t op;
    logic [ADDR_W-1:0] addr;
  } sese_cmd_t;

  typedef struct packed {
    logic is_write;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } sese_step_t;
endpackage

// >>> dv/sese_flash_model.sv
// Behavioural eight-bank flash device answering the host's bus cycles
`timescale 1ns/100ps
`default_nettype none
module sese_flash_model
  import sese_pkg::*;
#(
  parameter int WIN_CYC = 200,
  parameter int ERASE_CYC = 400,
  parameter int SUS_DLY = 20,
  parameter logic [8:0] PROT_SECT = 9'h045,
  parameter logic [15:0] LOCK_IND = 16'h0042
)(
  input wire logic ref_clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rst_n,
  output logic [DATA_W-1:0] dq_in,
  output logic ready_busy
);
  logic [28:0] h [1:5];
  logic [511:0] q = '0;
  logic [1:0] st = 2'd0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic asel = 1'b0;
  logic secure = 1'b0;
  logic tog = 1'b0;
  logic [2:0] bank_q = 3'd0;
  int tmr = 0;
  int nq = 0;
  int seqs = 0;
  int spend = 0;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] last_rd = 16'h0000;
  logic [7:0] cur;
  logic a555;
  logic u2;
  logic e6;
  logic bm;

  function automatic logic hit(logic [28:0] e, logic [10:0] a, logic [7:0] d);
    return e[18:8] == a && e[7:0] == d;
  endfunction

  assign cur = dq_out[7:0];
  assign a555 = addr[10:0] == 11'h555;
  assign u2 = hit(h[4], 11'h555, 8'hAA) && hit(h[5], 11'h2AA, 8'h55);
  assign e6 = u2 && hit(h[1], 11'h555, 8'hAA) && hit(h[2], 11'h2AA, 8'h55) &&
    hit(h[3], 11'h555, 8'h80);
  assign bm = addr[20:18] == bank_q;
  assign ready_busy = st != 2'd2;

  always_comb begin
    if (asel && addr[11:0] == 12'h002) begin
      rd = {15'h0000, addr[20:12] == PROT_SECT};
    end else if (asel && addr[11:0] == 12'h003) begin
      rd = LOCK_IND;
    end else if (st != 2'd0 && bm && (st != 2'd3 || q[addr[20:12]])) begin
      rd = {8'h00, 1'b0, tog, 6'h00};
    end else begin
      rd = addr[15:0] ^ 16'h5A5A;
    end
  end

  // Released bus shows the inverse of the last value
  assign dq_in = (!ce_n && !oe_n && !dq_oe) ? rd : ~last_rd;

  always @(posedge ref_clk) begin
    we_q <= we_n;
    oe_q <= oe_n;
    if (oe_n && !oe_q) tog <= ~tog;
    if (!ce_n && !oe_n) last_rd <= rd;
    if (!rst_n) begin
      st <= 2'd0;
      asel <= 1'b0;
      q <= '0;
      nq <= 0;
      spend <= 0;
    end else if (we_n && !we_q && !ce_n) begin
      for (int k = 1; k < 5; k++) h[k] <= h[k + 1];
      h[5] <= {addr, cur};
      case (st)
        2'd0: begin
          if (e6 && cur == 8'h30) begin
            st <= 2'd1;
            tmr <= 0;
            bank_q <= addr[20:18];
            q[addr[20:12]] <= 1'b1;
            nq <= 1;
            seqs <= seqs + 1;
          end else if (u2 && a555 && cur == 8'h88) begin
            secure <= 1'b1;
          end else if (u2 && a555 && cur == 8'h90) begin
            asel <= 1'b1;
          end else if (cur == 8'hF0) begin
            asel <= 1'b0;
          end
        end
        2'd1: begin
          if (cur == 8'h30) begin
            q[addr[20:12]] <= 1'b1;
            nq <= nq + 1;
            tmr <= 0;
          end else if (cur == 8'hB0 && bm) begin
            st <= 2'd3;
            tmr <= 0;
          end else begin
            st <= 2'd0;
            q <= '0;
            nq <= 0;
          end
        end
        2'd2: begin
          if (cur == 8'hB0 && bm && spend == 0) spend <= 1;
        end
        default: begin
          if (cur == 8'h30 && bm && !asel) st <= 2'd2;
          else if (u2 && a555 && cur == 8'h90) asel <= 1'b1;
          else if (cur == 8'hF0) asel <= 1'b0;
        end
      endcase
    end else begin
      if (st == 2'd1 && tmr >= WIN_CYC) begin
        st <= 2'd2;
        tmr <= 0;
      end else if (st == 2'd2 && spend == SUS_DLY) begin
        st <= 2'd3;
        spend <= 0;
      end else if (st == 2'd2 && tmr >= ERASE_CYC) begin
        st <= 2'd0;
        q <= '0;
        nq <= 0;
      end else if (st != 2'd3) begin
        tmr <= tmr + 1;
        if (spend > 0) spend <= spend + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/sese_host_bench.sv
// Self-checking bench for the sector erase and suspend host sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module sese_host_bench
  import sese_pkg::*;
;
  localparam int WIN = 200;
  localparam int SUS = 50;
  localparam logic [ADDR_W-1:0] BK1 = 21'h040000;
  localparam logic [ADDR_W-1:0] SEC_A = 21'h045000;
  localparam logic [ADDR_W-1:0] SEC_B = 21'h046000;
  localparam logic [ADDR_W-1:0] SEC_C = 21'h050123;
  localparam logic [ADDR_W-1:0] RD_O = 21'h100123;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  sese_cmd_t cmd = '{op: OP_READ, addr: ZERO_ADDR};
  logic cmd_ready_ff, done_ff, refused_ff, erase_active_ff, suspended_ff, window_open_ff;
  logic erase_window_expired_flag_ff, flash_dq_oe_ff, flash_ce_n_ff, flash_we_n_ff;
  logic flash_oe_n_ff, flash_rst_n_ff, ready_busy_output;
  logic [DATA_W-1:0] rdata_ff, flash_dq_out_ff, flash_dq_in;
  logic [ADDR_W-1:0] flash_addr_ff;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 ref_clk = ~ref_clk;

  sese_host #(.WINDOW_CYC(WIN), .SUSPEND_CYC(SUS)) dut_u (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_ff(cmd_ready_ff),
    .done_ff(done_ff), .refused_ff(refused_ff), .rdata_ff(rdata_ff),
    .erase_active_ff(erase_active_ff), .suspended_ff(suspended_ff),
    .window_open_ff(window_open_ff),
    .erase_window_expired_flag_ff(erase_window_expired_flag_ff),
    .flash_addr_ff(flash_addr_ff), .flash_dq_out_ff(flash_dq_out_ff),
    .flash_dq_oe_ff(flash_dq_oe_ff), .flash_dq_in(flash_dq_in),
    .flash_ce_n_ff(flash_ce_n_ff), .flash_we_n_ff(flash_we_n_ff),
    .flash_oe_n_ff(flash_oe_n_ff), .flash_rst_n_ff(flash_rst_n_ff),
    .ready_busy_output(ready_busy_output));

  sese_flash_model #(.WIN_CYC(WIN)) mdl_u (.ref_clk(ref_clk), .addr(flash_addr_ff),
    .dq_out(flash_dq_out_ff), .dq_oe(flash_dq_oe_ff), .ce_n(flash_ce_n_ff),
    .we_n(flash_we_n_ff), .oe_n(flash_oe_n_ff), .rst_n(flash_rst_n_ff),
    .dq_in(flash_dq_in), .ready_busy(ready_busy_output));

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Issue one request and check whether it is refused
  task automatic op(input sese_op_t o, input logic [ADDR_W-1:0] a, input logic exp_ref);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: o, addr: a};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    while (done_ff !== 1'b1 && refused_ff !== 1'b1 && n < 600) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("answer", 1'b1, done_ff | refused_ff)
    `CHK("refused", exp_ref, refused_ff)
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("ready", 1'b1, cmd_ready_ff)
    `CHK("flash reset", 1'b1, flash_rst_n_ff)
    op(OP_SUSPEND, BK1, 1'b1);
    op(OP_RESUME, BK1, 1'b1);
    op(OP_SECURE_ENTER, ZERO_ADDR, 1'b0);
    `CHK("secure", 1'b1, mdl_u.secure)
    op(OP_PROT_VERIFY, SEC_A, 1'b0);
    `CHK("prot a", 16'h0001, rdata_ff)
    op(OP_RESET, ZERO_ADDR, 1'b0);
    op(OP_PROT_VERIFY, SEC_B, 1'b0);
    `CHK("prot b", 16'h0000, rdata_ff)
    op(OP_RESET, ZERO_ADDR, 1'b0);
    op(OP_LOCK_READ, BK1, 1'b0);
    `CHK("lock", 16'h0042, rdata_ff)
    op(OP_RESET, ZERO_ADDR, 1'b0);
    op(OP_SECTOR_ERASE, SEC_A, 1'b0);
    `CHK("seqs", 1, mdl_u.seqs)
    `CHK("window", 1'b1, window_open_ff)
    `CHK("expired", 1'b0, erase_window_expired_flag_ff)
    op(OP_ADD_SECTOR, SEC_B, 1'b0);
    `CHK("queued", 2, mdl_u.nq)
    op(OP_READ, RD_O, 1'b1);
    op(OP_SECURE_ENTER, ZERO_ADDR, 1'b1);
    op(OP_SUSPEND, BK1, 1'b0);
    `CHK("susp now", 1'b1, suspended_ff)
    `CHK("expired", 1'b1, erase_window_expired_flag_ff)
    `CHK("dev susp", 2'd3, mdl_u.st)
    op(OP_READ, RD_O, 1'b0);
    `CHK("other bank", RD_O[15:0] ^ 16'h5A5A, rdata_ff)
    op(OP_READ, SEC_C, 1'b0);
    `CHK("free sector", SEC_C[15:0] ^ 16'h5A5A, rdata_ff)
    op(OP_PROT_VERIFY, SEC_A, 1'b0);
    `CHK("id in susp", 16'h0001, rdata_ff)
    op(OP_RESET, ZERO_ADDR, 1'b0);
    `CHK("back susp", 1'b1, suspended_ff)
    op(OP_RESUME, BK1, 1'b0);
    `CHK("resumed", 1'b0, suspended_ff)
    `CHK("dev erase", 2'd2, mdl_u.st)
    op(OP_RESUME, BK1, 1'b1);
    op(OP_READ, RD_O, 1'b1);
    op(OP_SUSPEND, BK1, 1'b0);
    for (int i = 0; i < SUS + 30 && suspended_ff !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("susp late", 1'b1, suspended_ff)
    op(OP_RESUME, BK1, 1'b0);
    for (int i = 0; i < 1000 && erase_active_ff !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("erase end", 1'b0, erase_active_ff)
    `CHK("dev idle", 2'd0, mdl_u.st)
    op(OP_READ, SEC_A, 1'b0);
    `CHK("array", SEC_A[15:0] ^ 16'h5A5A, rdata_ff)
    op(OP_SECTOR_ERASE, SEC_A, 1'b0);
    op(OP_RESET, ZERO_ADDR, 1'b0);
    `CHK("win abort", 1'b0, erase_active_ff)
    `CHK("win closed", 1'b0, window_open_ff)
    `CHK("dev read", 2'd0, mdl_u.st)
    op(OP_SECTOR_ERASE, SEC_B, 1'b0);
    for (int i = 0; i < WIN + 40 && window_open_ff !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("expired", 1'b1, erase_window_expired_flag_ff)
    op(OP_ADD_SECTOR, SEC_A, 1'b1);
    op(OP_RESET, ZERO_ADDR, 1'b1);
    op(OP_HW_RESET, ZERO_ADDR, 1'b0);
    `CHK("hw abort", 1'b0, erase_active_ff)
    `CHK("dev abort", 2'd0, mdl_u.st)
    close_out();
  end
endmodule
`default_nettype wire
